// *** src/ibaf_pkg.sv ***
// Package of constants for the initialization-block configuration and address filter
package ibaf_pkg;
    // ****************************************
    // Mode word fields
    // ****************************************
    localparam int MODE_RX_DISABLE_BIT = 0;
    localparam int MODE_TX_DISABLE_BIT = 1;
    localparam int MODE_LOOPBACK_BIT = 2;
    localparam int MODE_CRC_GEN_DISABLE_BIT = 3;
    localparam int MODE_INTERNAL_LOOP_BIT = 6;
    // ****************************************
    // Initialization block word indices (16-bit words)
    // ****************************************
    localparam logic [3:0] IB_MODE = 4'h0;
    localparam logic [3:0] IB_STATION0 = 4'h1;
    localparam logic [3:0] IB_STATION1 = 4'h2;
    localparam logic [3:0] IB_STATION2 = 4'h3;
    localparam logic [3:0] IB_HASH0 = 4'h4;
    localparam logic [3:0] IB_HASH3 = 4'h7;
    localparam logic [3:0] IB_RXPTR_LO = 4'h8;
    localparam logic [3:0] IB_RXPTR_HI = 4'h9;
    localparam logic [3:0] IB_TXPTR_LO = 4'hA;
    localparam logic [3:0] IB_TXPTR_HI = 4'hB;
    localparam logic [3:0] IB_LAST = 4'hB;
    // ****************************************
    // Ring pointer layout
    // ****************************************
    localparam int RING_LEN_MSB = 31;
    localparam int RING_LEN_LSB = 29;
    localparam int RING_BASE_MSB = 23;
    localparam int RING_BASE_LSB = 3;
    localparam logic [23:0] DESC_BYTES = 24'h000008;
    localparam int DESC_SHIFT = 3;
    localparam int MAX_RING_LOG2 = 7;
    // ****************************************
    // Loopback chaining limit and hash
    // ****************************************
    localparam logic [11:0] LOOP_RX_BUF_BYTES = 12'h020;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam int ADDR_BITS = 48;
    localparam int HASH_BITS = 6;
    localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        IBAF_IDLE = 2'b00,
        IBAF_LOAD = 2'b01,
        IBAF_DONE = 2'b11
    } ibaf_state_t;
endpackage : ibaf_pkg

// *** src/ibaf_hash.sv ***
// Serial CRC-32 hash of a group destination address
module ibaf_hash
    import ibaf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [47:0] addr,
    output logic busy,
    output logic done,
    output logic [5:0] hash_index
);
    logic [31:0] crc_ff;
    logic [47:0] sh_ff;
    logic [5:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [5:0] idx_ff;
    logic fb;
    // LSB of the address is the first bit on the wire
    assign fb = crc_ff[31] ^ sh_ff[0];
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            crc_ff <= CRC_INIT;
            sh_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            idx_ff <= '0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                crc_ff <= CRC_INIT;
                sh_ff <= addr;
                cnt_ff <= '0;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                crc_ff <= {crc_ff[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
                sh_ff <= {1'b0, sh_ff[47:1]};
                cnt_ff <= cnt_ff + 6'h01;
                if (cnt_ff == 6'(ADDR_BITS - 1)) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    // Latch the six top bits after the last address bit
                    idx_ff <= 6'(({crc_ff[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000)) >> (32 - HASH_BITS));
                end
            end
        end
    end
    assign busy = busy_ff;
    assign done = done_ff;
    assign hash_index = idx_ff;
endmodule : ibaf_hash

// *** src/ibaf_top.sv ***
// Initialization-block configuration, ring pointers and group address filter
// How it works
// - loopback forbids tx chaining; rx chaining needs 32-byte buffers
// - tx_disable blocks tx ring, clears transmitter_on_flag
// - rx_disable rejects packets, clears receiver_on_flag
// - first received address bit one means group
// - 64-bit hash mask from four 16-bit words
// - CRC the address, latch top six bits
// - selected mask bit accepts, otherwise reject
// - broadcast accepted whenever receiver on, bypasses hash mask
// - external loopback filters groups only with crc_gen_disable
// - three-bit length gives two-power ring entries
// - ring pointer bits 28:24 read as zero
// - ring base bits 23:3, quadword aligned
module ibaf_top
    import ibaf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic init_start,
    input wire logic ib_word_valid,
    input wire logic [15:0] ib_word,
    output logic ib_word_ready,
    output logic [3:0] ib_word_index,
    output logic init_done,
    output logic transmitter_on_flag,
    output logic receiver_on_flag,
    output logic [15:0] operating_mode_word,
    output logic [47:0] station_addr,
    output logic [63:0] group_hash_mask,
    output logic [31:0] receive_ring_pointer,
    output logic [31:0] transmit_ring_pointer,
    input wire logic rx_ring_advance,
    input wire logic tx_ring_advance,
    output logic [23:0] rx_entry_addr,
    output logic [23:0] tx_entry_addr,
    output logic rx_ring_fetch_en,
    output logic tx_ring_fetch_en,
    output logic tx_chain_allowed,
    input wire logic [11:0] rx_buf_bytes,
    output logic rx_chain_allowed,
    input wire logic dest_valid,
    input wire logic [47:0] dest_addr,
    output logic filter_done,
    output logic filter_accept
);
    ibaf_state_t state_ff;
    logic [15:0] mode_ff;
    logic [47:0] stn_ff;
    logic [63:0] hash_ff;
    logic [31:0] rxp_ff;
    logic [31:0] txp_ff;
    logic [3:0] idx_ff;
    logic tx_on_ff;
    logic rx_on_ff;
    logic [6:0] rx_idx_ff;
    logic [6:0] tx_idx_ff;
    logic [23:0] rx_addr_ff;
    logic [23:0] tx_addr_ff;
    logic pend_ff;
    logic fdone_ff;
    logic facc_ff;
    logic [47:0] dest_ff;
    logic hash_busy;
    logic hash_done;
    logic [5:0] hash_index;
    logic loading;
    logic loop_ext;
    logic group_filter_on;
    logic [6:0] rx_last;
    logic [6:0] tx_last;
    logic [6:0] nxt_rx_idx;
    logic [6:0] nxt_tx_idx;

    // ****************************************
    // Initialization block fetch
    // ****************************************
    assign loading = (state_ff == IBAF_LOAD);
    assign ib_word_ready = loading;
    assign ib_word_index = idx_ff;
    assign init_done = (state_ff == IBAF_DONE);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_ff <= IBAF_IDLE;
            idx_ff <= '0;
        end else begin
            case (state_ff)
                IBAF_IDLE: begin
                    if (init_start) begin
                        state_ff <= IBAF_LOAD;
                        idx_ff <= '0;
                    end
                end
                IBAF_LOAD: begin
                    if (ib_word_valid) begin
                        idx_ff <= idx_ff + 4'h1;
                        if (idx_ff == IB_LAST) begin
                            state_ff <= IBAF_DONE;
                        end
                    end
                end
                IBAF_DONE: begin
                    // Re-initialization restarts the fetch
                    if (init_start) begin
                        state_ff <= IBAF_LOAD;
                        idx_ff <= '0;
                    end
                end
                default: begin
                    state_ff <= IBAF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_ff <= '0;
            stn_ff <= '0;
            hash_ff <= '0;
            rxp_ff <= '0;
            txp_ff <= '0;
        end else if (loading && ib_word_valid) begin
            case (idx_ff)
                IB_MODE: mode_ff <= ib_word;
                IB_STATION0: stn_ff[15:0] <= ib_word;
                IB_STATION1: stn_ff[31:16] <= ib_word;
                IB_STATION2: stn_ff[47:32] <= ib_word;
                IB_RXPTR_LO: rxp_ff[15:3] <= ib_word[15:3];
                IB_RXPTR_HI: rxp_ff[31:16] <= {ib_word[15:13], 5'h00, ib_word[7:0]};
                IB_TXPTR_LO: txp_ff[15:3] <= ib_word[15:3];
                IB_TXPTR_HI: txp_ff[31:16] <= {ib_word[15:13], 5'h00, ib_word[7:0]};
                default: begin
                    if (idx_ff >= IB_HASH0 && idx_ff <= IB_HASH3) begin
                        hash_ff[16*(idx_ff - IB_HASH0) +: 16] <= ib_word;
                    end
                end
            endcase
        end
    end

    assign operating_mode_word = mode_ff;
    assign station_addr = stn_ff;
    assign group_hash_mask = hash_ff;
    assign receive_ring_pointer = rxp_ff;
    assign transmit_ring_pointer = txp_ff;

    // ****************************************
    // Engine enables
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_on_ff <= 1'b0;
            rx_on_ff <= 1'b0;
        end else if (loading && ib_word_valid && idx_ff == IB_LAST) begin
            tx_on_ff <= ~mode_ff[MODE_TX_DISABLE_BIT];
            rx_on_ff <= ~mode_ff[MODE_RX_DISABLE_BIT];
        end else if (init_start) begin
            tx_on_ff <= 1'b0;
            rx_on_ff <= 1'b0;
        end
    end
    assign transmitter_on_flag = tx_on_ff;
    assign receiver_on_flag = rx_on_ff;
    assign tx_ring_fetch_en = tx_on_ff && init_done;
    assign rx_ring_fetch_en = rx_on_ff && init_done;

    // Loopback leaves no time for a lookahead poll unless buffers are tiny
    assign tx_chain_allowed = ~mode_ff[MODE_LOOPBACK_BIT];
    assign rx_chain_allowed = ~mode_ff[MODE_LOOPBACK_BIT] || (rx_buf_bytes == LOOP_RX_BUF_BYTES);

    // ****************************************
    // Descriptor ring walk
    // ****************************************
    assign rx_last = 7'((8'h01 << rxp_ff[RING_LEN_MSB:RING_LEN_LSB]) - 8'h01);
    assign tx_last = 7'((8'h01 << txp_ff[RING_LEN_MSB:RING_LEN_LSB]) - 8'h01);
    assign nxt_rx_idx = (rx_idx_ff == rx_last) ? 7'h00 : rx_idx_ff + 7'h01;
    assign nxt_tx_idx = (tx_idx_ff == tx_last) ? 7'h00 : tx_idx_ff + 7'h01;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !init_done) begin
            rx_idx_ff <= '0;
            rx_addr_ff <= '0;
        end else begin
            if (rx_ring_advance && rx_ring_fetch_en) begin
                rx_idx_ff <= nxt_rx_idx;
            end
            rx_addr_ff <= {rxp_ff[RING_BASE_MSB:RING_BASE_LSB], 3'h0} + (24'(rx_idx_ff) << DESC_SHIFT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || !init_done) begin
            tx_idx_ff <= '0;
            tx_addr_ff <= '0;
        end else begin
            if (tx_ring_advance && tx_ring_fetch_en) begin
                tx_idx_ff <= nxt_tx_idx;
            end
            tx_addr_ff <= {txp_ff[RING_BASE_MSB:RING_BASE_LSB], 3'h0} + (24'(tx_idx_ff) << DESC_SHIFT);
        end
    end
    assign rx_entry_addr = rx_addr_ff;
    assign tx_entry_addr = tx_addr_ff;

    // ****************************************
    // Destination address filter
    // ****************************************
    assign loop_ext = mode_ff[MODE_LOOPBACK_BIT] && !mode_ff[MODE_INTERNAL_LOOP_BIT];
    assign group_filter_on = !loop_ext || mode_ff[MODE_CRC_GEN_DISABLE_BIT];

    ibaf_hash u_hash (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(pend_ff && !hash_busy),
        .addr(dest_ff),
        .busy(hash_busy),
        .done(hash_done),
        .hash_index(hash_index)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pend_ff <= 1'b0;
            dest_ff <= '0;
            fdone_ff <= 1'b0;
            facc_ff <= 1'b0;
        end else begin
            fdone_ff <= 1'b0;
            if (hash_busy) begin
                pend_ff <= 1'b0;
            end
            if (hash_done) begin
                fdone_ff <= 1'b1;
                facc_ff <= rx_on_ff && hash_ff[hash_index];
            end else if (dest_valid && !pend_ff && !hash_busy) begin
                dest_ff <= dest_addr;
                if (!rx_on_ff) begin
                    fdone_ff <= 1'b1;
                    facc_ff <= 1'b0;
                end else if (dest_addr == BCAST_ADDR) begin
                    fdone_ff <= 1'b1;
                    facc_ff <= 1'b1;
                end else if (dest_addr[0]) begin
                    if (group_filter_on) begin
                        pend_ff <= 1'b1;
                    end else begin
                        fdone_ff <= 1'b1;
                        facc_ff <= 1'b0;
                    end
                end else begin
                    fdone_ff <= 1'b1;
                    facc_ff <= (dest_addr == stn_ff);
                end
            end
        end
    end
    assign filter_done = fdone_ff;
    assign filter_accept = facc_ff;
endmodule : ibaf_top

// *** verif/ibaf_host_mem.sv ***
// Host-side shared memory model that serves the initialization block words
module ibaf_host_mem
    import ibaf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ib_word_ready,
    input wire logic [3:0] ib_word_index,
    input wire logic slow,
    output logic ib_word_valid,
    output logic [15:0] ib_word
);
    // ****************************************
    // Word server
    // ****************************************
    logic [15:0] mem [0:11];
    initial begin
        ib_word_valid = 1'b0;
        ib_word = 16'hA5A5;
    end
    // Idle data toggles every cycle so a stale word can never pass for a fresh one
    always @(negedge sys_clk) begin
        if (ib_word_valid && slow) begin
            ib_word_valid = 1'b0;
            ib_word = ~ib_word;
        end else if (ib_word_ready && ib_word_index <= IB_LAST) begin
            ib_word_valid = 1'b1;
            ib_word = mem[ib_word_index];
        end else begin
            ib_word_valid = 1'b0;
            ib_word = ~ib_word;
        end
    end
endmodule : ibaf_host_mem

// *** verif/ibaf_top_sva.sv ***
// Assertion checker for the configuration and address filter block
module ibaf_top_sva
    import ibaf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic init_done,
    input wire logic transmitter_on_flag,
    input wire logic receiver_on_flag,
    input wire logic [15:0] operating_mode_word,
    input wire logic [31:0] receive_ring_pointer,
    input wire logic [31:0] transmit_ring_pointer,
    input wire logic rx_ring_advance,
    input wire logic rx_ring_fetch_en,
    input wire logic tx_ring_fetch_en,
    input wire logic [23:0] rx_entry_addr,
    input wire logic tx_chain_allowed,
    input wire logic [11:0] rx_buf_bytes,
    input wire logic rx_chain_allowed,
    input wire logic dest_valid,
    input wire logic [47:0] dest_addr,
    input wire logic filter_done,
    input wire logic filter_accept
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic loop_m, nofilt;
    assign loop_m = operating_mode_word[MODE_LOOPBACK_BIT];
    // Treat filtering as off in any loopback, internal or external, unless the CRC generator is disabled
    assign nofilt = loop_m && !operating_mode_word[MODE_CRC_GEN_DISABLE_BIT];
    property p_fetch; {tx_ring_fetch_en, rx_ring_fetch_en} == ({2{init_done}} & {transmitter_on_flag, receiver_on_flag});
    endproperty
    a_fetch: assert property (p_fetch) else $error("ring fetch enable wrong");
    property p_flags; $rose(init_done) |-> {transmitter_on_flag, receiver_on_flag} == ~operating_mode_word[1:0];
    endproperty
    a_flags: assert property (p_flags) else $error("on flags wrong at init end");
    property p_tx_chain; loop_m |-> !tx_chain_allowed; endproperty
    a_tx_chain: assert property (p_tx_chain) else $error("tx chaining in loopback");
    property p_rx_chain; rx_chain_allowed == (!loop_m || rx_buf_bytes == LOOP_RX_BUF_BYTES); endproperty
    a_rx_chain: assert property (p_rx_chain) else $error("rx chaining wrong");
    property p_ptr_res; ((receive_ring_pointer | transmit_ring_pointer) & 32'h1F000007) == 32'h0; endproperty
    a_ptr_res: assert property (p_ptr_res) else $error("ring pointer reserved bits set");
    property p_bcast; dest_valid && dest_addr == BCAST_ADDR && receiver_on_flag |=> filter_done && filter_accept;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast not accepted");
    property p_off; dest_valid && !receiver_on_flag |=> filter_done && !filter_accept; endproperty
    a_off: assert property (p_off) else $error("packet taken with receiver off");
    property p_group; dest_valid && dest_addr[0] && dest_addr != BCAST_ADDR && receiver_on_flag && !nofilt
        |=> !filter_done [*8] ##[1:70] filter_done; endproperty
    a_group: assert property (p_group) else $error("group hash timing wrong");
    property p_ring; rx_ring_advance && rx_ring_fetch_en |-> ##2
        (rx_entry_addr == $past(rx_entry_addr, 2) + DESC_BYTES || rx_entry_addr == receive_ring_pointer[23:0]);
    endproperty
    a_ring: assert property (p_ring) else $error("rx entry address step wrong");
    c_accept: cover property (filter_done && filter_accept);
    c_init: cover property ($rose(init_done));
    c_wrap: cover property (rx_ring_advance ##2 rx_entry_addr == receive_ring_pointer[23:0]);
endmodule : ibaf_top_sva
bind ibaf_top ibaf_top_sva u_sva (.sys_clk, .resetn, .init_done, .transmitter_on_flag, .receiver_on_flag,
    .operating_mode_word, .receive_ring_pointer, .transmit_ring_pointer, .rx_ring_advance, .rx_ring_fetch_en,
    .tx_ring_fetch_en, .rx_entry_addr, .tx_chain_allowed, .rx_buf_bytes, .rx_chain_allowed, .dest_valid,
    .dest_addr, .filter_done, .filter_accept);

// *** verif/testbench.sv ***
// Testbench for the configuration and address filter block
module testbench
    import ibaf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Environment
    // ****************************************
    localparam logic [47:0] STN = 48'h0A1B2C3D4E50, G1 = 48'h0000015E0001, G2 = 48'h0000025E0003;
    logic sys_clk, resetn = 0, init_start = 0, rx_ring_advance = 0, tx_ring_advance = 0, dest_valid = 0, slow = 0;
    logic [11:0] rx_buf_bytes = 12'h020;
    logic [47:0] dest_addr = 48'h0, station_addr;
    logic ib_word_valid, ib_word_ready, init_done, transmitter_on_flag, receiver_on_flag, rx_ring_fetch_en;
    logic tx_ring_fetch_en, tx_chain_allowed, rx_chain_allowed, filter_done, filter_accept;
    logic [3:0] ib_word_index;
    logic [15:0] ib_word, operating_mode_word;
    logic [63:0] group_hash_mask, mask;
    logic [31:0] receive_ring_pointer, transmit_ring_pointer;
    logic [23:0] rx_entry_addr, tx_entry_addr;
    int n_errors = 0, comparisons = 0, cycles = 0;
    ibaf_top u_ibaf_top (.sys_clk, .resetn, .init_start, .ib_word_valid, .ib_word, .ib_word_ready, .ib_word_index,
        .init_done, .transmitter_on_flag, .receiver_on_flag, .operating_mode_word, .station_addr, .group_hash_mask,
        .receive_ring_pointer, .transmit_ring_pointer, .rx_ring_advance, .tx_ring_advance, .rx_entry_addr,
        .tx_entry_addr, .rx_ring_fetch_en, .tx_ring_fetch_en, .tx_chain_allowed, .rx_buf_bytes, .rx_chain_allowed,
        .dest_valid, .dest_addr, .filter_done, .filter_accept);
    ibaf_host_mem u_ibaf_host_mem (.sys_clk, .ib_word_ready, .ib_word_index, .slow, .ib_word_valid, .ib_word);
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Unreflected CRC, address fed first-received bit first
    function automatic logic [5:0] hash_of(input logic [47:0] a);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < ADDR_BITS; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? CRC_POLY : 32'h0);
        return c[31:26];
    endfunction : hash_of
    task init(input logic [15:0] mode, input logic [63:0] h, input logic [31:0] rxp, input logic [31:0] txp);
        int k;
        u_ibaf_host_mem.mem[0] = mode;
        for (k = 0; k < 3; k++) u_ibaf_host_mem.mem[1 + k] = STN[16 * k +: 16];
        for (k = 0; k < 4; k++) u_ibaf_host_mem.mem[4 + k] = h[16 * k +: 16];
        {u_ibaf_host_mem.mem[9], u_ibaf_host_mem.mem[8]} = rxp;
        {u_ibaf_host_mem.mem[11], u_ibaf_host_mem.mem[10]} = txp;
        @(negedge sys_clk) init_start = 1;
        @(negedge sys_clk) init_start = 0;
        for (k = 0; k < 100 && init_done !== 1'b1; k++) @(negedge sys_clk);
        check("init_done", init_done, 1);
        check("mode", operating_mode_word, mode);
        check("station", station_addr, STN);
        check("hash", group_hash_mask, h);
        check("rxptr", receive_ring_pointer, rxp & 32'hE0FFFFF8);
        check("txptr", transmit_ring_pointer, txp & 32'hE0FFFFF8);
        check("tx_on", {tx_ring_fetch_en, transmitter_on_flag}, {2{~mode[1]}});
        check("rx_on", {rx_ring_fetch_en, receiver_on_flag}, {2{~mode[0]}});
    endtask : init
    task dest(input logic [47:0] a, input logic exp);
        int k;
        dest_addr = a;
        dest_valid = 1;
        k = 0;
        do begin
            @(negedge sys_clk) dest_valid = 0;
            k++;
        end while (filter_done !== 1'b1 && k < 80);
        check("filter_done", filter_done, 1);
        check("accept", filter_accept, exp);
        @(negedge sys_clk);
    endtask : dest
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        mask = 64'h1 << hash_of(G1);
        repeat (10) @(negedge sys_clk);
        resetn = 1;
        // Host writes reserved pointer bits wrongly; the device must store zero there
        init(16'h0000, mask, 32'h5F001239, 32'h00000040);
        check("chain", {tx_chain_allowed, rx_chain_allowed}, 2'b11);
        dest(BCAST_ADDR, 1);
        dest(STN, 1);
        dest(STN ^ 48'h2, 0);
        dest(G1, 1);
        dest(G2, mask[hash_of(G2)]);
        for (int k = 1; k < 6; k++) begin
            @(negedge sys_clk) rx_ring_advance = 1;
            tx_ring_advance = 1;
            @(negedge sys_clk) rx_ring_advance = 0;
            tx_ring_advance = 0;
            repeat (2) @(negedge sys_clk);
            check("rx_entry", rx_entry_addr, 24'h001238 + 24'((k % 4) * 8));
            check("tx_entry", tx_entry_addr, 24'h000040);
        end
        slow = 1;
        init(16'h0003, mask, 32'h00000100, 32'h00000200);
        slow = 0;
        dest(BCAST_ADDR, 0);
        dest(G1, 0);
        init(16'h000C, 64'h0, 32'h00000100, 32'h00000200);
        check("tx_chain", tx_chain_allowed, 0);
        check("rx_chain32", rx_chain_allowed, 1);
        rx_buf_bytes = 12'h040;
        @(negedge sys_clk);
        check("rx_chain64", rx_chain_allowed, 0);
        dest(G1, 0);
        dest(BCAST_ADDR, 1);
        // External loopback filters groups only with the CRC generator off; internal loopback always filters
        init(16'h000C, mask, 32'h00000100, 32'h00000200);
        dest(G1, 1);
        init(16'h0004, mask, 32'h00000100, 32'h00000200);
        dest(G1, 0);
        init(16'h0044, mask, 32'h00000100, 32'h00000200);
        dest(G1, 1);
        conclude();
    end
endmodule : testbench
